/* File: design/dds_staged_waveform_generator.sv */
// staged direct digital synthesis engine with its stage fifo
module stage_fifo
#(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_state_t;
    fifo_state_t r;
    fifo_state_t next_r;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // handshake and pointer update
    assign in_ready = (r.count != (AW+1)'(DEPTH));
    assign out_valid = (r.count != '0);
    assign out_data = mem[r.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb
    begin
        next_r = r;
        if (push)
            next_r.wr_ptr = r.wr_ptr + 1'b1;
        if (pop)
            next_r.rd_ptr = r.rd_ptr + 1'b1;
        next_r.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // state register
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            r <= '0;
        else
            r <= next_r;
    end

    // storage
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[r.wr_ptr] <= in_data;
    end
endmodule

module dds_staged_waveform_generator
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // lookup memory load
    input wire logic wave_wr,
    input wire logic [dds_pkg::WAVE_ADDR_W-1:0] wave_addr,
    input wire logic [dds_pkg::SAMPLE_W-1:0] wave_data,
    // stage entries: frequency word and duration in sample clocks
    input wire logic stage_valid,
    output logic stage_ready,
    input wire logic [dds_pkg::PHASE_W-1:0] stage_freq,
    input wire logic [31:0] stage_time,
    input wire logic list_clear,
    // generation control
    input wire logic func_mode,
    input wire logic start_gen,
    input wire logic stop_gen,
    input wire logic soft_trigger,
    input wire logic external_trigger_in,
    input wire logic soft_reset,
    // configuration write
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_trig_mode,
    input wire logic cfg_trig_ext,
    input wire logic cfg_filter_en,
    input wire logic cfg_out_en,
    // analog selection write
    input wire logic analog_wr,
    input wire logic [6:0] analog_atten_db,
    input wire logic analog_filter_sel,
    input wire logic analog_imp_75,
    input wire logic analog_ref_ext,
    input wire logic [6:0] analog_sync_duty,
    // status sources
    input wire logic pll_locked,
    input wire logic host_access,
    // converter side
    output logic [dds_pkg::SAMPLE_W-1:0] dac_data,
    output logic dac_update,
    output logic output_relay,
    // analog selections
    output logic [6:0] atten_db,
    output logic analog_filter_en,
    output logic impedance_75,
    output logic ref_external,
    output logic [6:0] sync_duty,
    // status
    output logic [1:0] gen_state,
    output logic [8:0] stage_index,
    output logic [9:0] list_count,
    output logic lock_led_amber,
    output logic access_led_green,
    output logic access_led_yellow
);
    import dds_pkg::*;

    typedef struct packed {
        gen_state_t state;
        logic [PHASE_W-1:0] phase;
        logic [PHASE_W-1:0] freq;
        logic [31:0] remain;
        logic [8:0] idx;
        logic [9:0] count;
        logic step_pend;
        logic [7:0] tick_acc;
        logic dac_phase;
        logic [SAMPLE_W-1:0] dac_data;
        logic dac_update;
        logic [SAMPLE_W-1:0] mem_q;
        logic [FILTER_LATENCY-2:0][SAMPLE_W-1:0] pipe;
        logic [2:0] trig_sync;
        logic trig_stable;
        logic [2:0] lock_sync;
        logic lock_stable;
        logic access_q;
        logic [1:0] trig_mode;
        logic trig_ext;
        logic filter_en;
        logic out_en;
        logic [6:0] atten;
        logic afilt;
        logic imp75;
        logic ref_ext;
        logic [6:0] duty;
    } core_state_t;

    core_state_t r;
    core_state_t next_r;
    logic [SAMPLE_W-1:0] wave_mem [WAVE_DEPTH];
    logic [STAGE_W-1:0] list_mem [LIST_DEPTH];
    logic [STAGE_W-1:0] fifo_data;
    logic fifo_valid;
    logic list_ready;
    logic list_accept;
    logic [8:0] sum9;
    logic dac_tick;
    logic sample_tick;
    logic ext_edge;
    logic trig;
    logic [PHASE_W:0] phase_sum;
    logic wrap;
    logic last_stage;
    logic advance;
    logic [8:0] next_idx;
    logic [STAGE_W-1:0] next_entry;
    logic signed [SAMPLE_W:0] mid_sum;

    // host stage entries are buffered, then copied into the list while idle
    stage_fifo #(.WIDTH(STAGE_W), .DEPTH(STAGE_FIFO_DEPTH)) i_stage_fifo
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(stage_valid),
        .in_ready(stage_ready),
        .in_data({stage_freq, stage_time}),
        .out_valid(fifo_valid),
        .out_ready(list_ready),
        .out_data(fifo_data)
    );
    assign list_ready = (r.state == ST_IDLE) && (r.count < LIST_LIMIT) && !list_clear;
    assign list_accept = fifo_valid && list_ready;

    // tick generation and stage selection
    assign sum9 = {1'b0, r.tick_acc} + TICK_STEP;
    assign dac_tick = (sum9 >= TICK_MODULUS);
    assign sample_tick = dac_tick && r.dac_phase;
    assign ext_edge = (r.trig_sync[1] == r.trig_sync[2]) && r.trig_sync[2] && !r.trig_stable;
    assign trig = r.trig_ext ? ext_edge : soft_trigger;
    assign phase_sum = {1'b0, r.phase} + {1'b0, r.freq};
    assign wrap = phase_sum[PHASE_W];
    assign last_stage = ({1'b0, r.idx} == (r.count - 10'h001));
    assign next_idx = last_stage ? 9'h000 : r.idx + 9'h001;
    assign next_entry = list_mem[advance ? next_idx : 9'h000];
    assign mid_sum = $signed({r.pipe[FILTER_LATENCY-2][SAMPLE_W-1], r.pipe[FILTER_LATENCY-2]})
        + $signed({r.pipe[FILTER_LATENCY-3][SAMPLE_W-1], r.pipe[FILTER_LATENCY-3]});

    // stage advance decision: time expiry or paced by trigger
    always_comb
    begin
        advance = 1'b0;
        if (r.state == ST_RUN && sample_tick)
        begin
            if (r.trig_mode == TRIG_STEPPED)
                advance = r.step_pend && wrap;
            else
                advance = (r.remain <= 32'h0000_0001);
        end
    end

    // next state
    always_comb
    begin
        next_r = r;
        next_r.tick_acc = dac_tick ? 8'(sum9 - TICK_MODULUS) : sum9[7:0];
        next_r.dac_update = dac_tick;
        if (dac_tick)
            next_r.dac_phase = ~r.dac_phase;
        // input synchronisers; change accepted once second and third agree
        next_r.trig_sync = {r.trig_sync[1:0], external_trigger_in};
        if (r.trig_sync[1] == r.trig_sync[2])
            next_r.trig_stable = r.trig_sync[2];
        next_r.lock_sync = {r.lock_sync[1:0], pll_locked};
        if (r.lock_sync[1] == r.lock_sync[2])
            next_r.lock_stable = r.lock_sync[2];
        next_r.access_q = host_access;
        // list fill counter
        if (list_clear)
            next_r.count = 10'h000;
        else if (list_accept)
            next_r.count = r.count + 10'h001;
        // accumulator runs whatever the output relay does
        if (sample_tick && (r.state == ST_RUN || r.state == ST_LAST))
            next_r.phase = phase_sum[PHASE_W-1:0];
        // lookup read, then fixed delay line
        if (sample_tick)
        begin
            next_r.mem_q = func_mode ? wave_mem[r.phase[PHASE_W-1:WAVE_ADDR_LSB]] : '0;
            next_r.pipe = {r.pipe[FILTER_LATENCY-3:0], r.mem_q};
        end
        // interpolate by two at the converter rate
        if (sample_tick)
            next_r.dac_data = r.pipe[FILTER_LATENCY-2];
        else if (dac_tick)
            next_r.dac_data = r.filter_en ? mid_sum[SAMPLE_W:1] : r.pipe[FILTER_LATENCY-2];
        // stepped triggers wait for the waveform to complete; a set wins over the clear
        next_r.step_pend = (r.step_pend && !advance) ||
            (r.state == ST_RUN && r.trig_mode == TRIG_STEPPED && trig);
        // sequencer
        case (r.state)
            ST_IDLE:
            begin
                next_r.step_pend = 1'b0;
                if (start_gen && r.count != 10'h000 && !list_clear)
                    next_r.state = ST_ARMED;
            end
            ST_ARMED:
            begin
                next_r.step_pend = 1'b0;
                if (trig)
                begin
                    next_r.state = ST_RUN;
                    next_r.idx = 9'h000;
                    next_r.phase = '0;
                    next_r.freq = next_entry[STAGE_W-1:32];
                    next_r.remain = next_entry[31:0];
                end
            end
            ST_RUN:
            begin
                if (sample_tick && !advance)
                    next_r.remain = r.remain - 32'h0000_0001;
                if (advance && last_stage && r.trig_mode == TRIG_SINGLE)
                    next_r.state = ST_LAST;
                else if (advance)
                begin
                    next_r.idx = next_idx;
                    next_r.freq = next_entry[STAGE_W-1:32];
                    next_r.remain = next_entry[31:0];
                end
            end
            ST_LAST:
                next_r.state = ST_LAST;
            default:
                next_r.state = ST_IDLE;
        endcase
        if (stop_gen)
            next_r.state = ST_IDLE;
        // configuration and analog selections
        if (cfg_wr)
        begin
            next_r.trig_mode = cfg_trig_mode;
            next_r.trig_ext = cfg_trig_ext;
            next_r.filter_en = cfg_filter_en;
            next_r.out_en = cfg_out_en;
        end
        if (analog_wr)
        begin
            next_r.atten = analog_atten_db;
            next_r.afilt = analog_filter_sel;
            next_r.imp75 = analog_imp_75;
            next_r.ref_ext = analog_ref_ext;
            next_r.duty = analog_sync_duty;
        end
        if (soft_reset)
        begin
            next_r.state = ST_IDLE;
            next_r.trig_mode = RST_TRIG_MODE;
            next_r.trig_ext = RST_TRIG_EXT;
            next_r.filter_en = RST_FILTER_EN;
            next_r.out_en = RST_OUT_EN;
            next_r.atten = RST_ATTEN_DB;
            next_r.afilt = RST_ANALOG_FILTER;
            next_r.imp75 = RST_IMPEDANCE_75;
            next_r.ref_ext = RST_REF_EXTERNAL;
            next_r.duty = RST_SYNC_DUTY;
        end
    end

    // state register; power-up leaves analog fields at the soft defaults
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            r <= '0;
            r.state <= ST_IDLE;
            r.trig_mode <= RST_TRIG_MODE;
            r.trig_ext <= RST_TRIG_EXT;
            r.filter_en <= RST_FILTER_EN;
            r.out_en <= RST_OUT_EN;
            r.afilt <= RST_ANALOG_FILTER;
            r.duty <= RST_SYNC_DUTY;
        end
        else
            r <= next_r;
    end

    // lookup memory and staging list storage
    always_ff @(posedge sys_clk)
    begin
        if (wave_wr)
            wave_mem[wave_addr] <= wave_data;
        if (list_accept)
            list_mem[r.count[8:0]] <= fifo_data;
    end

    // outputs
    assign dac_data = r.dac_data;
    assign dac_update = r.dac_update;
    assign output_relay = r.out_en;
    assign atten_db = r.atten;
    assign analog_filter_en = r.afilt;
    assign impedance_75 = r.imp75;
    assign ref_external = r.ref_ext;
    assign sync_duty = r.duty;
    assign gen_state = r.state;
    assign stage_index = r.idx;
    assign list_count = r.count;
    assign lock_led_amber = r.lock_stable;
    assign access_led_green = !r.access_q;
    assign access_led_yellow = r.access_q;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_phase_step: assert property (
        sample_tick && r.state == ST_RUN |=> r.phase == $past(phase_sum[PHASE_W-1:0]))
        else $error("phase did not advance by frequency word");
    chk_arb_silent: assert property (
        sample_tick && !func_mode |=> r.mem_q == '0)
        else $error("lookup read outside synthesis mode");
    chk_bypass_latency: assert property (
        sample_tick |=> dac_data == $past(r.pipe[FILTER_LATENCY-2]))
        else $error("sample tick output not from end of delay line");
    chk_dac_spacing: assert property (
        dac_update |=> !dac_update ##1 !dac_update)
        else $error("converter updates too close together");
    chk_soft_defaults: assert property (
        soft_reset |=> !output_relay && r.trig_mode == TRIG_CONT && r.filter_en && !r.trig_ext)
        else $error("soft reset did not restore power-up state");
    chk_analog_defaults: assert property (
        soft_reset |=> atten_db == 7'h00 && analog_filter_en && !impedance_75
            && !ref_external && sync_duty == 7'h32)
        else $error("soft reset did not restore analog selections");
    chk_access_led: assert property (
        host_access |=> access_led_yellow && !access_led_green)
        else $error("access indicator not yellow during host access");
    chk_off_runs: assert property (
        r.state == ST_RUN && !output_relay && sample_tick && r.freq != '0
            |=> r.phase != $past(r.phase))
        else $error("generation stalled while output disabled");
    chk_last_hold: assert property (
        r.state == ST_LAST && !stop_gen && !soft_reset |=> r.state == ST_LAST)
        else $error("last stage left without stop");
    chk_list_limit: assert property (
        r.count <= LIST_LIMIT)
        else $error("staging list above its depth");
    chk_stage_hold: assert property (
        r.state == ST_RUN && sample_tick && r.trig_mode != TRIG_STEPPED
            && r.remain > 32'h1 && !stop_gen && !soft_reset |=> r.idx == $past(r.idx))
        else $error("stage advanced before its time expired");

    cov_single_last: cover property (r.state == ST_RUN ##1 r.state == ST_LAST);
    cov_cont_wrap: cover property (advance && last_stage && r.trig_mode == TRIG_CONT);
    cov_stepped: cover property (advance && r.trig_mode == TRIG_STEPPED);
    cov_ext_start: cover property (r.state == ST_ARMED && r.trig_ext && ext_edge);
endmodule

/* File: design/dds_pkg.sv */
// constants and types shared by the staged waveform synthesis engine
// Overview of operation
// - 32-bit phase accumulator indexes lookup, 12-bit samples
// - lookup holds one waveform of 16384 samples
// - read position wraps from last to first
// - lookup memory sources samples only in synthesis
// - one frequency word changes output frequency
// - up to 16 MHz, 9.31 mHz step
// - each stage is frequency plus time word
// - stage frequency lasts its time, then advance
// - no iteration count; time or trigger paces
// - staging list holds at most 512 stages
// - every stage reads the same lookup waveform
// - interpolation filter path latency is 26 samples
// - filter bypass keeps the 26 sample latency
// - converter updated 80 MHz, memory read 40 MHz
// - power-up: output off, continuous, software trigger, filter
// - power-up sets analog selections to the soft reset defaults
// - soft reset also restores analog defaults
// - lock indicator dark unlocked, amber when locked
// - activity indicator green powered, yellow on access
// - generation keeps running while output is off
// - continuous mode loops the list until stopped
// - single mode runs once, repeats last stage
// - stepped mode advances per trigger at waveform end
package dds_pkg;
    // clock rates in MHz; tick generator adds dac rate modulo system rate
    localparam int SYS_CLK_MHZ = 250;
    localparam int DAC_CLK_MHZ = 80;
    localparam int SAMPLE_CLK_MHZ = 40;
    localparam logic [8:0] TICK_MODULUS = 9'(SYS_CLK_MHZ);
    localparam logic [8:0] TICK_STEP = 9'(DAC_CLK_MHZ);
    localparam int DAC_PER_SAMPLE = DAC_CLK_MHZ / SAMPLE_CLK_MHZ;
    // datapath sizes
    localparam int PHASE_W = 32;
    localparam int SAMPLE_W = 12;
    localparam int WAVE_ADDR_W = 14;
    localparam int WAVE_DEPTH = 16384;
    localparam int WAVE_ADDR_LSB = PHASE_W - WAVE_ADDR_W;
    localparam int LIST_DEPTH = 512;
    localparam logic [9:0] LIST_LIMIT = 10'h200;
    localparam int STAGE_W = 64;
    localparam int STAGE_FIFO_DEPTH = 16;
    localparam int FILTER_LATENCY = 26;
    localparam int MIN_STAGE_US = 3;
    // trigger modes
    localparam logic [1:0] TRIG_CONT = 2'h0;
    localparam logic [1:0] TRIG_SINGLE = 2'h1;
    localparam logic [1:0] TRIG_STEPPED = 2'h2;
    // power-up values of the configuration
    localparam logic [1:0] RST_TRIG_MODE = TRIG_CONT;
    localparam logic RST_TRIG_EXT = 1'h0;
    localparam logic RST_FILTER_EN = 1'h1;
    localparam logic RST_OUT_EN = 1'h0;
    // analog selections restored by a software reset
    localparam logic [6:0] RST_ATTEN_DB = 7'h00;
    localparam logic RST_ANALOG_FILTER = 1'h1;
    localparam logic RST_IMPEDANCE_75 = 1'h0;
    localparam logic RST_REF_EXTERNAL = 1'h0;
    localparam logic [6:0] RST_SYNC_DUTY = 7'h32;
    // sequencer states, gray along idle-armed-run-last
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ARMED = 2'h1,
        ST_RUN = 2'h3,
        ST_LAST = 2'h2
    } gen_state_t;
endpackage

/* File: sim/dac_model.sv */
// converter model: counts updates, tracks sample step and connector level
module dac_model
(
    // clock
    input wire logic sys_clk,
    // converter side
    input wire logic [dds_pkg::SAMPLE_W-1:0] dac_data,
    input wire logic dac_update,
    input wire logic output_relay,
    // observations
    output int n_upd,
    output logic [dds_pkg::SAMPLE_W-1:0] cur,
    output logic [dds_pkg::SAMPLE_W-1:0] step,
    output logic [dds_pkg::SAMPLE_W-1:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    import dds_pkg::*;
    // converter idles at midscale zero
    initial
    begin
        n_upd = 0;
        cur = '0;
        step = '0;
    end
    // word latched on each update strobe; step kept from the last change
    always @(posedge sys_clk)
    begin
        if (dac_update === 1'h1)
        begin
            n_upd <= n_upd + 1;
            if (dac_data !== cur)
                step <= dac_data - cur;
            cur <= dac_data;
        end
    end
    // relay grounds the connector while off
    assign pin_level = (output_relay === 1'h1) ? cur : '0;
endmodule

/* File: sim/tb.sv */
// bench for the staged synthesis engine driving a converter model
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dds_pkg::*;
    localparam logic [6:0] P_START = 7'h40, P_STOP = 7'h20, P_TRIG = 7'h10, P_SRST = 7'h08;
    localparam logic [6:0] P_CLR = 7'h04, P_CFG = 7'h02, P_ANA = 7'h01;
    logic sys_clk, reset, wave_wr, stage_valid, list_clear, func_mode, start_gen, stop_gen;
    logic soft_trigger, external_trigger_in, soft_reset, cfg_wr, cfg_trig_ext, cfg_filter_en;
    logic cfg_out_en, analog_wr, analog_filter_sel, analog_imp_75, analog_ref_ext;
    logic pll_locked, host_access, stage_ready, dac_update, output_relay, analog_filter_en;
    logic impedance_75, ref_external, lock_led_amber, access_led_green, access_led_yellow;
    logic [WAVE_ADDR_W-1:0] wave_addr;
    logic [SAMPLE_W-1:0] wave_data, dac_data, cur, step, pin_level;
    logic [PHASE_W-1:0] stage_freq;
    logic [31:0] stage_time;
    logic [1:0] cfg_trig_mode, gen_state;
    logic [6:0] analog_atten_db, analog_sync_duty, atten_db, sync_duty;
    logic [8:0] stage_index;
    logic [9:0] list_count;
    int errors, cmp_count, n_upd, n0;
    dds_staged_waveform_generator i_dds_staged_waveform_generator (.sys_clk, .reset,
        .wave_wr, .wave_addr, .wave_data, .stage_valid, .stage_ready, .stage_freq, .stage_time,
        .list_clear, .func_mode, .start_gen, .stop_gen, .soft_trigger, .external_trigger_in,
        .soft_reset, .cfg_wr, .cfg_trig_mode, .cfg_trig_ext, .cfg_filter_en, .cfg_out_en,
        .analog_wr, .analog_atten_db, .analog_filter_sel, .analog_imp_75, .analog_ref_ext,
        .analog_sync_duty, .pll_locked, .host_access, .dac_data, .dac_update, .output_relay,
        .atten_db, .analog_filter_en, .impedance_75, .ref_external, .sync_duty, .gen_state,
        .stage_index, .list_count, .lock_led_amber, .access_led_green, .access_led_yellow);
    dac_model i_dac_model (.sys_clk, .dac_data, .dac_update, .output_relay, .n_upd, .cur,
        .step, .pin_level);
    // 250 MHz clock
    initial
    begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    // verdict and end of run
    task automatic wrap_up;
        if (errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic timeout;
        errors++;
        wrap_up();
    endtask
    // compare seen against expected
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [31:0] pick(input int w);
        case (w)
            0: return 32'(gen_state);
            1: return 32'(stage_index);
            2: return 32'(list_count);
            default: return 32'(lock_led_amber);
        endcase
    endfunction
    // bounded wait for a status value, then compare it
    task automatic wt(input int w, input logic [31:0] v, input int bound);
        int i;
        for (i = 0; i < bound; i++)
        begin
            @(negedge sys_clk);
            if (pick(w) === v)
                break;
        end
        if (i == bound)
            timeout();
        chk("watch", pick(w), v);
    endtask
    // one-cycle control strobes
    task automatic pulse(input logic [6:0] m);
        @(posedge sys_clk);
        {start_gen, stop_gen, soft_trigger, soft_reset, list_clear, cfg_wr, analog_wr} <= m;
        @(posedge sys_clk);
        {start_gen, stop_gen, soft_trigger, soft_reset, list_clear, cfg_wr, analog_wr} <= 7'h00;
    endtask
    task automatic cfg(input logic [1:0] md, input logic ext, input logic flt, input logic oe);
        @(posedge sys_clk);
        {cfg_trig_mode, cfg_trig_ext, cfg_filter_en, cfg_out_en} <= {md, ext, flt, oe};
        pulse(P_CFG);
    endtask
    // one stage entry, held until accepted
    task automatic push(input logic [31:0] f, input logic [31:0] t);
        int i;
        @(posedge sys_clk);
        {stage_valid, stage_freq, stage_time} <= {1'h1, f, t};
        for (i = 0; i < 40; i++)
        begin
            @(negedge sys_clk);
            if (stage_ready === 1'h1)
                break;
        end
        if (i == 40)
            timeout();
        @(posedge sys_clk);
        stage_valid <= 1'h0;
    endtask
    // main sequence
    initial
    begin
        errors = 0;
        cmp_count = 0;
        {wave_wr, wave_addr, wave_data, stage_valid, stage_freq, stage_time, list_clear} = '0;
        {func_mode, start_gen, stop_gen, soft_trigger, external_trigger_in, soft_reset} = '0;
        {cfg_wr, cfg_trig_mode, cfg_trig_ext, cfg_filter_en, cfg_out_en, analog_wr} = '0;
        {analog_atten_db, analog_filter_sel, analog_imp_75, analog_ref_ext} = '0;
        {analog_sync_duty, pll_locked, host_access} = '0;
        reset = 1'h1;
        repeat (4) @(posedge sys_clk);
        reset <= 1'h0;
        @(negedge sys_clk);
        chk("relay", output_relay, 32'h0);
        chk("analog", {atten_db, analog_filter_en, impedance_75, ref_external, sync_duty},
            {7'h00, 1'h1, 1'h0, 1'h0, 7'h32});
        chk("leds", {lock_led_amber, access_led_green, access_led_yellow}, 32'h2);
        chk("idle", {gen_state, list_count}, 32'h0);
        // status indicators
        @(posedge sys_clk);
        pll_locked <= 1'h1;
        host_access <= 1'h1;
        wt(3, 32'h1, 10);
        chk("access", {access_led_green, access_led_yellow}, 32'h1);
        @(posedge sys_clk);
        pll_locked <= 1'h0;
        host_access <= 1'h0;
        wt(3, 32'h0, 10);
        // analog selections, output enable, then software reset
        @(posedge sys_clk);
        {analog_atten_db, analog_filter_sel, analog_imp_75, analog_ref_ext, analog_sync_duty}
            <= {7'h49, 1'h0, 1'h1, 1'h1, 7'h14};
        pulse(P_ANA);
        cfg(TRIG_STEPPED, 1'h1, 1'h0, 1'h1);
        @(negedge sys_clk);
        chk("relay", output_relay, 32'h1);
        chk("analog", {atten_db, impedance_75, sync_duty}, {7'h49, 1'h1, 7'h14});
        pulse(P_SRST);
        @(negedge sys_clk);
        chk("relay", output_relay, 32'h0);
        chk("analog", {atten_db, analog_filter_en, impedance_75, ref_external, sync_duty},
            {7'h00, 1'h1, 1'h0, 1'h0, 7'h32});
        // ramp waveform over the whole lookup
        for (int a = 0; a < WAVE_DEPTH; a++)
        begin
            @(posedge sys_clk);
            {wave_wr, wave_addr, wave_data, func_mode} <= {1'h1, 14'(a), 12'(a), 1'h1};
        end
        @(posedge sys_clk);
        wave_wr <= 1'h0;
        push(32'h0004_0000, 32'd200);
        push(32'h0008_0000, 32'd200);
        wt(2, 32'h2, 10);
        // power-up defaults: continuous mode, software trigger
        pulse(P_START);
        wt(0, 32'h1, 5);
        pulse(P_TRIG);
        wt(0, 32'h3, 5);
        repeat (300) @(negedge sys_clk);
        chk("step", step, 32'h1);
        chk("pin", pin_level, 32'h0);
        n0 = n_upd;
        repeat (250) @(negedge sys_clk);
        chk("rate", 32'(n_upd - n0), 32'd80);
        cfg(TRIG_CONT, 1'h0, 1'h0, 1'h0);
        wt(1, 32'h1, 2000);
        repeat (300) @(negedge sys_clk);
        chk("step", step, 32'h2);
        wt(1, 32'h0, 2000);
        @(posedge sys_clk);
        func_mode <= 1'h0;
        repeat (300) @(negedge sys_clk);
        chk("zero", cur, 32'h0);
        @(posedge sys_clk);
        func_mode <= 1'h1;
        // stage buffer fills while running and refuses the extra entry
        for (int k = 0; k < STAGE_FIFO_DEPTH; k++)
            push(32'(k), 32'd200);
        @(posedge sys_clk);
        stage_valid <= 1'h1;
        @(negedge sys_clk);
        chk("ready", stage_ready, 32'h0);
        @(posedge sys_clk);
        stage_valid <= 1'h0;
        pulse(P_STOP);
        wt(2, 32'd18, 100);
        pulse(P_CLR);
        wt(2, 32'h0, 5);
        // single mode holds the last stage
        push(32'h0004_0000, 32'd200);
        push(32'h0008_0000, 32'd200);
        cfg(TRIG_SINGLE, 1'h0, 1'h0, 1'h0);
        pulse(P_START);
        pulse(P_TRIG);
        wt(0, 32'h2, 4000);
        chk("index", stage_index, 32'h1);
        repeat (300) @(negedge sys_clk);
        chk("step", step, 32'h2);
        pulse(P_STOP);
        wt(0, 32'h0, 5);
        pulse(P_CLR);
        // stepped mode paced by the external pin
        push(32'h4000_0000, 32'd200);
        push(32'h4000_0000, 32'd200);
        cfg(TRIG_STEPPED, 1'h1, 1'h1, 1'h1);
        pulse(P_START);
        wt(0, 32'h1, 5);
        @(posedge sys_clk);
        external_trigger_in <= 1'h1;
        wt(0, 32'h3, 10);
        repeat (2000) @(negedge sys_clk);
        chk("index", stage_index, 32'h0);
        @(posedge sys_clk);
        external_trigger_in <= 1'h0;
        repeat (4) @(posedge sys_clk);
        external_trigger_in <= 1'h1;
        wt(1, 32'h1, 60);
        pulse(P_STOP);
        pulse(P_CLR);
        // list stops at its 512 entry limit
        for (int k = 0; k <= LIST_DEPTH; k++)
            push(32'h0004_0000, 32'd200);
        repeat (20) @(negedge sys_clk);
        chk("count", list_count, 32'h200);
        wrap_up();
    end
endmodule
